//--- inc/cmc_defs.vh
// register offsets, field positions, reset values and timing for the can mode control block
`ifndef CMC_DEFS_VH
`define CMC_DEFS_VH
`define CMC_OFS_CTRL0 8'h00
`define CMC_OFS_CTRL1 8'h04
`define CMC_OFS_BTR0 8'h08
`define CMC_OFS_BTR1 8'h0c
`define CMC_OFS_IDAC 8'h10
`define CMC_OFS_IRQ_STAT 8'h14
`define CMC_OFS_IRQ_MASK 8'h18
`define CMC_OFS_STATUS 8'h1c
`define CMC_OFS_ACC_CODE 8'h20
`define CMC_OFS_ACC_MASK 8'h40
// control zero fields
`define CMC_C0_INIT_REQUEST 0
`define CMC_C0_SLEEP_REQUEST 1
`define CMC_C0_WAKE_EN 2
// control one fields
`define CMC_C1_ENABLE 7
`define CMC_C1_CLOCK_SOURCE_SELECT 6
`define CMC_C1_LOOP 5
`define CMC_C1_LISTEN 4
`define CMC_C1_WFILT 2
`define CMC_C1_SLEEP_ACKNOWLEDGE 1
`define CMC_C1_INIT_ACKNOWLEDGE 0
`define CMC_C1_WMASK 8'hf4
// interrupt status fields
`define CMC_IRQ_WAKE 0
`define CMC_IRQ_TXDONE 1
`define CMC_IRQ_RXDONE 2
`define CMC_IRQ_INIT 3
`define CMC_IRQ_W 4
// reset values
`define CMC_RST_CTRL0 8'h01
`define CMC_RST_CTRL1 8'h01
// wake filter time
`define CMC_TWUP_NS 2000
`define CMC_CLK_NS 10
`define CMC_TWUP_CYC ((`CMC_TWUP_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`endif

//--- verilog/cmc_mode_control.v
// mode, handshake and loopback control for a can controller, wishbone slave
//
// Overview of operation
// - control one takes writes only while init request and init acknowledge are both 1.
// - enable bit writes once in normal operation, freely in special, init mode only.
// - enable bit 0 disables the controller, 1 lets it run.
// - clock source bit picks oscillator clock at 0, bus clock at 1.
// - loopback feeds the transmit bit stream straight to the receiver input.
// - in loopback the receive pin is ignored and transmit pin held recessive.
// - in loopback the receiver disregards the acknowledge slot bit.
// - loopback still raises transmit-complete and receive interrupts.
// - listen-only receives matching frames but never drives ack or error frames.
// - listen-only freezes the transmit and receive error counters.
// - listen-only blocks the start of any transmission.
// - wake filter 0 wakes on any dominant level, 1 needs a long pulse.
// - sleep is a request/acknowledge handshake, active when both are 1.
// - asleep with wake enabled, bus activity clears sleep acknowledge.
// - init is a request/acknowledge handshake, active when both are 1.
// - control one, timing, acceptance control, code and mask regs need init mode.
`include "cmc_defs.vh"
module cmc_mode_control #(
	parameter TWUP_CYC = `CMC_TWUP_CYC
) (
	input wire clk,
	input wire rst_b,
	input wire special_mode,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire bus_receive_pin,
	output reg bus_transmit_pin,
	input wire core_tx_bit,
	output reg core_rx_bit,
	input wire core_tx_ack_bit,
	input wire core_tx_error_bit,
	output reg core_ignore_ack,
	input wire core_tx_start_req,
	output wire core_tx_start,
	output wire core_err_count_en,
	input wire core_tx_done,
	input wire core_rx_done,
	input wire core_idle,
	output wire module_enable,
	output wire clock_source_select,
	output wire irq
);
	localparam ST_RUN = 4'h1;
	localparam ST_INIT = 4'h2;
	localparam ST_SLEEP = 4'h4;
	localparam ST_WAKE = 4'h8;
	localparam CW = 16;

	reg [7:0] control_zero;
	reg [7:0] control_one;
	reg [7:0] bit_timing_zero;
	reg [7:0] bit_timing_one;
	reg [7:0] acceptance_control;
	reg [7:0] acceptance_code_regs [0:7];
	reg [7:0] acceptance_mask_regs [0:7];
	reg [`CMC_IRQ_W-1:0] irq_stat;
	reg [`CMC_IRQ_W-1:0] irq_mask;
	reg enable_written;
	reg [3:0] state;
	reg [3:0] next_state;
	reg rx_s1, rx_s2, rx_s3;
	reg [CW-1:0] dom_cnt;
	reg wake_hit;
	reg next_wake_hit;
	reg [31:0] next_dat;
	integer i;

	wire init_req = control_zero[`CMC_C0_INIT_REQUEST];
	wire sleep_req = control_zero[`CMC_C0_SLEEP_REQUEST];
	wire wake_en = control_zero[`CMC_C0_WAKE_EN];
	wire init_ack = control_one[`CMC_C1_INIT_ACKNOWLEDGE];
	wire sleep_ack = control_one[`CMC_C1_SLEEP_ACKNOWLEDGE];
	wire loop_en = control_one[`CMC_C1_LOOP];
	wire listen = control_one[`CMC_C1_LISTEN];
	wire init_mode = init_req & init_ack;
	wire sleep_mode = sleep_req & sleep_ack;
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = req & wb_we_i & wb_sel_i[0];
	wire rd = req & ~wb_we_i;
	wire rx_level = rx_s3; // third stage taken as is; only the dominant detect needs second and third stages to agree
	wire rx_dominant = (rx_s2 == rx_s3) & ~rx_s3;

	// matches a word-aligned byte address inside a 32-byte acceptance bank
	function hit_bank;
		input [7:0] adr;
		input [7:0] base;
		begin
			hit_bank = (adr[7:5] == base[7:5]) & (adr[1:0] == 2'b00);
		end
	endfunction

	assign module_enable = control_one[`CMC_C1_ENABLE];
	assign clock_source_select = control_one[`CMC_C1_CLOCK_SOURCE_SELECT];
	// a disabled, initialising, sleeping or listening controller may not start frames
	assign core_tx_start = core_tx_start_req & module_enable & ~listen & state[0];
	assign core_err_count_en = module_enable & ~listen;
	assign irq = |(irq_stat & irq_mask);

	// loopback and listen-only pin routing
	always @* begin
		core_rx_bit = loop_en ? core_tx_bit : rx_level;
		core_ignore_ack = loop_en;
		if (loop_en | ~module_enable) begin
			bus_transmit_pin = 1'b1;
		end else if (listen) begin
			bus_transmit_pin = 1'b1; // no ack, no error frame
		end else begin
			bus_transmit_pin = core_tx_bit & core_tx_ack_bit & core_tx_error_bit;
		end
	end

	// three stage pin synchroniser
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_s3 <= 1'b1;
		end else begin
			rx_s1 <= bus_receive_pin;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
		end
	end

	// wake detector: filter select chooses any dominant or a long dominant pulse
	always @* begin
		if (control_one[`CMC_C1_WFILT]) begin
			next_wake_hit = rx_dominant & (dom_cnt >= TWUP_CYC[CW-1:0] - 16'h0001);
		end else begin
			next_wake_hit = rx_dominant;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dom_cnt <= 16'h0000;
			wake_hit <= 1'b0;
		end else begin
			wake_hit <= next_wake_hit;
			if (!rx_dominant || !state[2]) begin
				dom_cnt <= 16'h0000;
			end else if (dom_cnt != 16'hffff) begin
				dom_cnt <= dom_cnt + 16'h0001;
			end
		end
	end

	// mode state machine; init request outranks sleep
	always @* begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (init_req) begin
					next_state = ST_INIT;
				end else if (sleep_req && core_idle) begin
					next_state = ST_SLEEP;
				end
			end
			ST_INIT: begin
				if (!init_req) begin
					next_state = ST_RUN;
				end
			end
			ST_SLEEP: begin
				if (init_req) begin
					next_state = ST_INIT;
				end else if (wake_en && wake_hit) begin
					next_state = ST_WAKE;
				end else if (!sleep_req) begin
					next_state = ST_RUN;
				end
			end
			ST_WAKE: begin
				next_state = ST_RUN;
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	// read mux; unmapped addresses read zero
	always @* begin
		next_dat = 32'h00000000;
		case (wb_adr_i)
			`CMC_OFS_CTRL0: next_dat = {24'h000000, control_zero};
			`CMC_OFS_CTRL1: next_dat = {24'h000000, control_one};
			`CMC_OFS_BTR0: next_dat = {24'h000000, bit_timing_zero};
			`CMC_OFS_BTR1: next_dat = {24'h000000, bit_timing_one};
			`CMC_OFS_IDAC: next_dat = {24'h000000, acceptance_control};
			`CMC_OFS_IRQ_STAT: next_dat = {28'h0000000, irq_stat};
			`CMC_OFS_IRQ_MASK: next_dat = {28'h0000000, irq_mask};
			`CMC_OFS_STATUS: next_dat = {28'h0000000, state};
			default: begin
				if (hit_bank(wb_adr_i, `CMC_OFS_ACC_CODE)) begin
					next_dat = {24'h000000, acceptance_code_regs[wb_adr_i[4:2]]};
				end else if (hit_bank(wb_adr_i, `CMC_OFS_ACC_MASK)) begin
					next_dat = {24'h000000, acceptance_mask_regs[wb_adr_i[4:2]]};
				end
			end
		endcase
	end

	// register file, handshake flags and interrupt status
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			control_zero <= `CMC_RST_CTRL0;
			control_one <= `CMC_RST_CTRL1;
			bit_timing_zero <= 8'h00;
			bit_timing_one <= 8'h00;
			acceptance_control <= 8'h00;
			irq_stat <= 4'h0;
			irq_mask <= 4'h0;
			enable_written <= 1'b0;
			state <= ST_INIT;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			for (i = 0; i < 8; i = i + 1) begin
				acceptance_code_regs[i] <= 8'h00;
				acceptance_mask_regs[i] <= 8'h00;
			end
		end else begin
			state <= next_state;
			wb_ack_o <= req; // single wait state, every address answers
			if (rd) begin
				wb_dat_o <= next_dat;
			end
			if (wr && wb_adr_i == `CMC_OFS_CTRL0) begin
				control_zero <= wb_dat_i[7:0] & 8'h07;
			end
			if (wr && wb_adr_i == `CMC_OFS_IRQ_MASK) begin
				irq_mask <= wb_dat_i[`CMC_IRQ_W-1:0];
			end
			// protected group; other writes fall through silently
			if (wr && init_mode) begin
				if (wb_adr_i == `CMC_OFS_CTRL1) begin
					control_one[6:2] <= wb_dat_i[6:2] & 5'h1d;
					if (special_mode || !enable_written) begin
						control_one[`CMC_C1_ENABLE] <= wb_dat_i[`CMC_C1_ENABLE];
						enable_written <= 1'b1;
					end
				end
				if (wb_adr_i == `CMC_OFS_BTR0) begin
					bit_timing_zero <= wb_dat_i[7:0];
				end
				if (wb_adr_i == `CMC_OFS_BTR1) begin
					bit_timing_one <= wb_dat_i[7:0];
				end
				if (wb_adr_i == `CMC_OFS_IDAC) begin
					acceptance_control <= wb_dat_i[7:0];
				end
				if (hit_bank(wb_adr_i, `CMC_OFS_ACC_CODE)) begin
					acceptance_code_regs[wb_adr_i[4:2]] <= wb_dat_i[7:0];
				end
				if (hit_bank(wb_adr_i, `CMC_OFS_ACC_MASK)) begin
					acceptance_mask_regs[wb_adr_i[4:2]] <= wb_dat_i[7:0];
				end
			end
			// acknowledge flags follow the state, never software
			control_one[`CMC_C1_INIT_ACKNOWLEDGE] <= next_state[1];
			control_one[`CMC_C1_SLEEP_ACKNOWLEDGE] <= next_state[2];
			// sticky events; a set in the read cycle survives the clear
			irq_stat <= ((rd && wb_adr_i == `CMC_OFS_IRQ_STAT) ? 4'h0 : irq_stat)
				| {next_state[1] & ~state[1], core_rx_done, core_tx_done,
				state[3]};
		end
	end
endmodule // cmc_mode_control

//--- test/cmc_bus_node.sv
// can line model: wired-and bus with one remote dominant driver
module cmc_bus_node (
	input wire tx_pin,
	input wire remote_dom,
	output wire rx_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// pulled recessive, any dominant driver wins
	assign rx_pin = tx_pin & ~remote_dom;
endmodule // cmc_bus_node

//--- test/cmc_mode_control_assertions.sv
// port assertions for the can mode control block
module cmc_mode_chk (
	input wire clk,
	input wire rst_b,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire bus_receive_pin,
	input wire bus_transmit_pin,
	input wire core_tx_bit,
	input wire core_rx_bit,
	input wire core_ignore_ack,
	input wire core_tx_start,
	input wire core_err_count_en,
	input wire module_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// a taken request gets exactly one ack pulse
	sequence s_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	chk_ack_pulse: assert property (s_taken |=> s_pulse)
		else $error("ack pulse wrong");
	chk_ack_idle: assert property (!wb_stb_i |=> !wb_ack_o)
		else $error("ack with no request");
	chk_loop_route: assert property (core_ignore_ack |-> core_rx_bit == core_tx_bit)
		else $error("loopback not routed");
	chk_loop_pin: assert property (core_ignore_ack |-> bus_transmit_pin)
		else $error("pin driven in loopback");
	// pin reaches the core three edges later
	chk_rx_delay: assert property ((!core_ignore_ack) [*4]
		|-> core_rx_bit == $past(bus_receive_pin, 3)) else $error("receive delay wrong");
	chk_listen_pin: assert property (module_enable && !core_err_count_en
		&& core_tx_bit && !core_ignore_ack |-> bus_transmit_pin) else $error("listen drove bus");
	chk_listen_start: assert property (module_enable && !core_err_count_en
		|-> !core_tx_start) else $error("start while listening");
	chk_off_quiet: assert property (!module_enable
		|-> !core_tx_start && !core_err_count_en) else $error("disabled core active");
endmodule // cmc_mode_chk
bind cmc_mode_control cmc_mode_chk u_cmc_mode_chk (.clk(clk), .rst_b(rst_b),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.bus_receive_pin(bus_receive_pin), .bus_transmit_pin(bus_transmit_pin),
	.core_tx_bit(core_tx_bit), .core_rx_bit(core_rx_bit), .core_ignore_ack(core_ignore_ack),
	.core_tx_start(core_tx_start), .core_err_count_en(core_err_count_en),
	.module_enable(module_enable));

//--- test/tb_top.sv
// self-checking bench for the can mode control block
`include "cmc_defs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, spm = 0, txb = 1, ackb = 1, sreq = 0, txd = 0, rxd = 0;
	logic idle = 1, dom = 0, cyc = 0, stb = 0, we = 0, errb = 1;
	logic [7:0] adr = 0;
	logic [31:0] wd = 0, rd;
	wire [31:0] dat;
	wire ack, rxp, txp, crx, ign, tst, ecen, men, csel, irq;
	int err_total = 0, tests_run = 0;
	// address, value written, value read back
	logic [7:0] rows [7][3] = '{'{8'h08, 8'ha5, 8'ha5}, '{8'h0c, 8'h5a, 8'h5a},
		'{8'h10, 8'h3c, 8'h3c}, '{8'h20, 8'h81, 8'h81}, '{8'h5c, 8'h7e, 8'h7e},
		'{8'h18, 8'h0f, 8'h0f}, '{8'h04, 8'hde, 8'hd5}};
	always #5 clk = ~clk;
	cmc_mode_control #(.TWUP_CYC(4)) u_cmc_mode_control (.clk(clk), .rst_b(rst_b),
		.special_mode(spm), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack),
		.bus_receive_pin(rxp), .bus_transmit_pin(txp), .core_tx_bit(txb), .core_rx_bit(crx),
		.core_tx_ack_bit(ackb), .core_tx_error_bit(errb), .core_ignore_ack(ign),
		.core_tx_start_req(sreq), .core_tx_start(tst), .core_err_count_en(ecen),
		.core_tx_done(txd), .core_rx_done(rxd), .core_idle(idle), .module_enable(men),
		.clock_source_select(csel), .irq(irq));
	cmc_bus_node u_cmc_bus_node (.tx_pin(txp), .remote_dom(dom), .rx_pin(rxp));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("FAIL %0t got %h want %h", $time, s, e);
		end
	endtask
	// request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		{cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
		do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
		// a missing ack is a mismatch of its own
		if (ack !== 1'b1) begin
			err_total++;
			$display("FAIL %0t no ack", $time);
		end
		rd = dat;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// done pulses from both directions
	task automatic evt;
		{txd, rxd} <= 2'b11;
		@(posedge clk);
		{txd, rxd} <= 2'b00;
		repeat (2) @(posedge clk);
	endtask
	task automatic finish_test;
		if (err_total == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// hang guard, far above the run length
	initial begin
		#100us;
		err_total++;
		finish_test;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1;
		rdc(`CMC_OFS_CTRL0, `CMC_RST_CTRL0);
		rdc(`CMC_OFS_CTRL1, `CMC_RST_CTRL1);
		foreach (rows[i]) begin
			wb(1'b1, rows[i][0], {24'h0, rows[i][1]});
			rdc(rows[i][0], {24'h0, rows[i][2]});
		end
		chk(32'({men, csel, ecen}), 32'h6);
		// listen: no start, ack drive kept off the pin
		{sreq, ackb, errb} <= 3'b100;
		@(posedge clk);
		chk(32'({tst, txp}), 32'h1);
		{ackb, errb} <= 2'b11;
		// status read clears, mask gates the line
		wb(1'b0, `CMC_OFS_IRQ_STAT, 32'h0);
		evt();
		chk(32'(irq), 32'h1);
		rdc(`CMC_OFS_IRQ_STAT, 32'h06);
		wb(1'b1, `CMC_OFS_IRQ_MASK, 32'h0);
		evt();
		chk(32'(irq), 32'h0);
		// enable sticks in normal operation only
		wb(1'b1, `CMC_OFS_CTRL1, 32'h0);
		rdc(`CMC_OFS_CTRL1, 32'h81);
		spm <= 1;
		wb(1'b1, `CMC_OFS_CTRL1, 32'h20);
		rdc(`CMC_OFS_CTRL1, 32'h21);
		// loopback: own bit returns, remote dominant ignored
		{txb, dom} <= 2'b01;
		@(posedge clk);
		chk(32'({ign, txp, crx}), 32'h6);
		txb <= 1;
		@(posedge clk);
		chk(32'(crx), 32'h1);
		dom <= 0;
		// sleep, a short glitch, then a real wake
		wb(1'b1, `CMC_OFS_CTRL1, 32'h84);
		wb(1'b1, `CMC_OFS_CTRL0, 32'h06);
		repeat (4) @(posedge clk);
		rdc(`CMC_OFS_CTRL1, 32'h86);
		{idle, dom} <= 2'b01;
		repeat (2) @(posedge clk);
		dom <= 0;
		repeat (8) @(posedge clk);
		rdc(`CMC_OFS_CTRL1, 32'h86);
		wb(1'b1, `CMC_OFS_CTRL1, 32'h0);
		wb(1'b1, 8'h08, 32'h11);
		dom <= 1;
		repeat (12) @(posedge clk);
		rdc(`CMC_OFS_CTRL1, 32'h84);
		rdc(8'h08, 32'ha5);
		// mid-run reset puts the block back into init mode
		dom <= 0;
		@(posedge clk);
		rst_b <= 0;
		repeat (3) @(posedge clk);
		rst_b <= 1;
		rdc(`CMC_OFS_CTRL1, `CMC_RST_CTRL1);
		rdc(8'h08, 32'h0);
		finish_test;
	end
endmodule // tb_top
